// ### hw/ext_ctrl_pkg.sv
// constants for the extended control register of a 10/100 phy
// assumes a management frame engine outside that delivers register accesses
package ext_ctrl_pkg;

	localparam logic [4:0]  EXT_CTRL_ADDR     = 5'h10;
	localparam int          REG_W             = 16;
	localparam int          ADDR_W            = 5;
	localparam int          BIT_OVR_WE        = 15;
	localparam int          BIT_ADDR_LO       = 6;
	localparam int          BIT_ADDR_HI       = 10;
	localparam int          BIT_LOCK_TEST     = 5;
	localparam int          BIT_NRZI          = 3;
	localparam int          BIT_INV_CODE      = 2;
	localparam int          BIT_SCR_DIS       = 0;
	localparam logic [15:0] EXT_CTRL_RESET    = 16'h0008;
	// bits that software may store: 15, 5, 3, 2, 0
	localparam logic [15:0] EXT_CTRL_WR_MASK  = 16'h802D;

endpackage

// ### hw/ext_ctrl_if.sv
// carrier between the register bank and its transmit code translator
// assumes both ends share ref_clk_i
`timescale 1ns/1ps
`default_nettype none
interface ext_ctrl_if;
	logic       inv_code_en;
	logic       tx_err;
	logic [3:0] nibble;
	logic [4:0] code;

	modport bank  (output inv_code_en, output tx_err, output nibble, input code);
	modport xlate (input inv_code_en, input tx_err, input nibble, output code);
endinterface
`default_nettype wire

// ### hw/code_xlate.sv
// 4b/5b transmit code translator with an invalid-code test table
// assumes nibbles arrive synchronous to ref_clk_i; code is registered
`timescale 1ns/1ps
`default_nettype none
module code_xlate (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	input  wire logic clk_en_i,
	// carrier
	ext_ctrl_if.xlate x
);
	logic [4:0] code_q;
	logic [4:0] code_d;
	logic [4:0] std_code;
	logic [4:0] alt_code;

	// ==========================================================
	// standard table
	always_comb begin
		unique case (x.nibble)
			4'h0: std_code = 5'h1E;
			4'h1: std_code = 5'h09;
			4'h2: std_code = 5'h14;
			4'h3: std_code = 5'h15;
			4'h4: std_code = 5'h0A;
			4'h5: std_code = 5'h0B;
			4'h6: std_code = 5'h0E;
			4'h7: std_code = 5'h0F;
			4'h8: std_code = 5'h12;
			4'h9: std_code = 5'h13;
			4'hA: std_code = 5'h16;
			4'hB: std_code = 5'h17;
			4'hC: std_code = 5'h1A;
			4'hD: std_code = 5'h1B;
			4'hE: std_code = 5'h1C;
			4'hF: std_code = 5'h1D;
		endcase
	end

	// ==========================================================
	// alternate table
	always_comb begin
		unique case (x.nibble)
			4'h8: alt_code = 5'h00;
			4'h9: alt_code = 5'h0D;
			4'hA: alt_code = 5'h0C;
			4'hB: alt_code = 5'h11;
			4'hC: alt_code = 5'h10;
			4'hD: alt_code = 5'h19;
			4'hE: alt_code = 5'h18;
			4'hF: alt_code = 5'h1F;
			// RULE12: leading zero prepended
			default: alt_code = {1'b0, x.nibble};
		endcase
	end

	always_comb begin
		// RULE11: standard when test off
		code_d = std_code;
		// RULE12: alternate needs tx error too
		// RULE13: upper nibbles from table
		if (x.inv_code_en && x.tx_err) begin
			code_d = alt_code;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			code_q <= 5'h00;
		end else if (clk_en_i) begin
			code_q <= code_d;
		end
	end

	assign x.code = code_q;
endmodule
`default_nettype wire

// ### hw/phy_extended_control.sv
// extended control register bank of a 10/100 phy, reached through a
// decoded management access port (register address, write strobe, data)
// assumes the frame engine gives one-cycle strobes synchronous to ref_clk_i
//
// Behaviour
// RULE1: register 16 at address 0x10, 16 bits
// RULE2: override enable unlocks protected bits next write
// RULE3: override enable self-clears after next write; here a write to register 16 loads bit 15 from its data
// RULE4: reserved bits 14:11, 4, 1 read zero
// RULE5: manager writes defaults into reserved bits
// RULE6: bits 10:6 hold port address
// RULE7: address latched from led pins at reset
// RULE8: software reset keeps latched address
// RULE9: lock test bit forces descrambler unlock
// RULE10: bit 3 selects nrz or nrzi
// RULE11: bit 2 clear gives standard 4b/5b
// RULE12: bit2 and txer: low nibbles zero-prefixed
// RULE13: high nibbles use alternate fixed table
// RULE14: bit 0 disables scrambler and descrambler
// RULE15: scrambling only applies at 100 Mb/s
// RULE16: protected bits hold without override enable
`timescale 1ns/1ps
`default_nettype none
module phy_extended_control
	import ext_ctrl_pkg::*;
#(
	parameter logic [15:0] PROTECTED_MASK = 16'h0000
) (
	// clock, reset, enable
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         soft_rst_i,
	input  wire logic                         clk_en_i,
	// management access port
	input  wire logic [ext_ctrl_pkg::ADDR_W-1:0] mgmt_addr_i,
	input  wire logic                         mgmt_wr_i,
	input  wire logic [ext_ctrl_pkg::REG_W-1:0]  mgmt_wdata_i,
	output logic      [ext_ctrl_pkg::REG_W-1:0]  mgmt_rdata_o,
	output logic                              mgmt_hit_o,
	// strap pins shared with led outputs
	input  wire logic                         addr4_rxled_pin_i,
	input  wire logic                         addr3_txled_pin_i,
	input  wire logic                         addr2_linkled_pin_i,
	input  wire logic                         addr1_colled_pin_i,
	input  wire logic                         addr0_actled_pin_i,
	// datapath controls
	input  wire logic                         speed_100_i,
	input  wire logic                         tx_err_i,
	input  wire logic [3:0]                   tx_nibble_i,
	output logic      [4:0]                   tx_code_o,
	output logic      [4:0]                   phy_addr_o,
	output logic                              override_en_o,
	output logic                              force_unlock_o,
	output logic                              nrzi_sel_o,
	output logic                              scram_en_o,
	output logic                              descram_en_o
);
	import ext_ctrl_pkg::*;

	// elaboration check: a protected bit must also be a storable bit
	if ((PROTECTED_MASK & ~EXT_CTRL_WR_MASK) != 16'h0000) begin : g_bad_mask
		$error("protected mask covers bits that cannot be written");
	end

	ext_ctrl_if cif ();

	// ==========================================================
	// control bits
	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic [4:0]  addr_q;
	logic [4:0]  addr_d;
	logic        strap_pend_q;
	logic        strap_pend_d;
	logic        wr_hit;
	logic        ovr_q;

	assign ovr_q = ctrl_q[BIT_OVR_WE];
	// RULE1: decode register 16
	assign wr_hit = mgmt_wr_i && (mgmt_addr_i == EXT_CTRL_ADDR);

	always_comb begin
		ctrl_d = ctrl_q;
		// RULE3: clears after any management write to another address; a write to register 16 loads bit 15 from the data
		if (mgmt_wr_i) begin
			ctrl_d[BIT_OVR_WE] = 1'b0;
		end
		if (wr_hit) begin
			// RULE2: override lets protected bits change
			// RULE16: otherwise protected bits hold
			if (ovr_q) begin
				ctrl_d = (ctrl_q & ~EXT_CTRL_WR_MASK)
					| (mgmt_wdata_i & EXT_CTRL_WR_MASK);
			end else begin
				ctrl_d = (ctrl_q & ~(EXT_CTRL_WR_MASK & ~PROTECTED_MASK))
					| (mgmt_wdata_i & EXT_CTRL_WR_MASK & ~PROTECTED_MASK);
			end
		end
		if (soft_rst_i) begin
			ctrl_d = EXT_CTRL_RESET;
		end
	end

	// ==========================================================
	// strap capture: taken on the first enabled edge after reset release
	always_comb begin
		addr_d       = addr_q;
		strap_pend_d = 1'b0;
		// RULE7: sample led pins after reset
		// RULE8: soft reset does not touch this
		if (strap_pend_q) begin
			addr_d = {addr4_rxled_pin_i, addr3_txled_pin_i, addr2_linkled_pin_i,
				addr1_colled_pin_i, addr0_actled_pin_i};
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctrl_q       <= EXT_CTRL_RESET;
			addr_q       <= 5'h00;
			strap_pend_q <= 1'b1;
		end else if (clk_en_i) begin
			ctrl_q       <= ctrl_d;
			addr_q       <= addr_d;
			strap_pend_q <= strap_pend_d;
		end
	end

	// ==========================================================
	// read data, registered
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        hit_q;
	logic        hit_d;

	always_comb begin
		hit_d   = (mgmt_addr_i == EXT_CTRL_ADDR);
		// RULE4: reserved bits masked to zero
		rdata_d = ctrl_q & EXT_CTRL_WR_MASK;
		// RULE6: address field read only
		rdata_d[BIT_ADDR_HI:BIT_ADDR_LO] = addr_q;
		if (!hit_d) begin
			rdata_d = 16'h0000;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_q <= 16'h0000;
			hit_q   <= 1'b0;
		end else if (clk_en_i) begin
			rdata_q <= rdata_d;
			hit_q   <= hit_d;
		end
	end

	assign mgmt_rdata_o = rdata_q;
	assign mgmt_hit_o   = hit_q;

	// ==========================================================
	// datapath control outputs
	assign phy_addr_o     = addr_q;
	assign override_en_o  = ovr_q;
	// RULE9: forced loss of descrambler lock
	assign force_unlock_o = ctrl_q[BIT_LOCK_TEST] && speed_100_i;
	// RULE10: line coding select
	assign nrzi_sel_o     = ctrl_q[BIT_NRZI];
	// RULE14: one bit disables both directions
	// RULE15: gated off in 10 Mb/s operation
	assign scram_en_o     = !ctrl_q[BIT_SCR_DIS] && speed_100_i;
	assign descram_en_o   = !ctrl_q[BIT_SCR_DIS] && speed_100_i;

	assign cif.inv_code_en = ctrl_q[BIT_INV_CODE];
	assign cif.tx_err      = tx_err_i;
	assign cif.nibble      = tx_nibble_i;
	assign tx_code_o       = cif.code;

	code_xlate u_xlate (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clk_en_i  (clk_en_i),
		.x         (cif.xlate)
	);
endmodule
`default_nettype wire

// ### tb/phy_extended_control_sva.sv
// checker bound into the extended control bank
// assumes it sees only the bank's own ports
`timescale 1ns/1ps
`default_nettype none
module phy_extended_control_sva
	import ext_ctrl_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        clk_en_i,
	// management and controls
	input wire logic [4:0]  mgmt_addr_i,
	input wire logic        mgmt_wr_i,
	input wire logic [15:0] mgmt_wdata_i,
	input wire logic [15:0] mgmt_rdata_o,
	input wire logic        mgmt_hit_o,
	input wire logic        speed_100_i,
	input wire logic [4:0]  phy_addr_o,
	input wire logic        override_en_o,
	input wire logic        force_unlock_o,
	input wire logic        scram_en_o,
	input wire logic        descram_en_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// ====
	// assertions
	a_hit_latency: assert property (!$past(rst_i) && $past(clk_en_i) |->
		mgmt_hit_o == ($past(mgmt_addr_i) == EXT_CTRL_ADDR)) else $error("hit late");
	a_rsvd_zero: assert property ((mgmt_rdata_o & 16'h7812) == 0) else $error("rsvd");
	a_addr_field: assert property (mgmt_hit_o |-> mgmt_rdata_o[10:6] == phy_addr_o)
		else $error("addr field");
	a_addr_hold: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
		$stable(phy_addr_o)) else $error("addr moved");
	a_ovr_set: assert property ($past(mgmt_wr_i && clk_en_i && mgmt_wdata_i[15] &&
		mgmt_addr_i == EXT_CTRL_ADDR) |-> override_en_o) else $error("ovr unset");
	a_ovr_clear: assert property ($past(mgmt_wr_i && clk_en_i && override_en_o &&
		mgmt_addr_i != EXT_CTRL_ADDR) |-> !override_en_o) else $error("ovr stuck");
	a_scram_pair: assert property (scram_en_o == descram_en_o) else $error("pair");
	a_scram_10m: assert property (!speed_100_i |-> !scram_en_o && !force_unlock_o)
		else $error("10M scram");
	c_hit: cover property (mgmt_hit_o);
	c_ovr: cover property ($rose(override_en_o));
	c_unlock: cover property (force_unlock_o);
endmodule
bind phy_extended_control phy_extended_control_sva i_phy_extended_control_sva (.ref_clk_i,
	.rst_i, .clk_en_i, .mgmt_addr_i, .mgmt_wr_i, .mgmt_wdata_i, .mgmt_rdata_o, .mgmt_hit_o,
	.speed_100_i, .phy_addr_o, .override_en_o, .force_unlock_o, .scram_en_o, .descram_en_o);
`default_nettype wire

// ### tb/sta_model.sv
// management station model: register reads and writes
// assumes the bank takes a one-cycle write strobe on a rising edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module sta_model (
	// clock
	input  wire logic       clk_i,
	// access port
	output var logic [4:0]  addr_o = 5'h00,
	output var logic        wr_o = 1'b0,
	output var logic [15:0] wdata_o = 16'h0000,
	output var logic        look_o = 1'b0
);
	// ====
	// bus cycles
	// one write per call, data as the caller gives it
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		// released data shows the inverse, never a stale copy
		wdata_o <= ~d;
	endtask
	task automatic rd_reg(input logic [4:0] a);
		@(posedge clk_i);
		addr_o <= a;
		look_o <= 1'b1;
		@(posedge clk_i);
		look_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// bench for the extended control bank and its code translator
// assumes sta_model drives the management port
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ext_ctrl_pkg::*;
	localparam logic [4:0] STD [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
		5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	localparam logic [4:0] ALT [8] = '{5'h00, 5'h0D, 5'h0C, 5'h11, 5'h10, 5'h19, 5'h18, 5'h1F};
	logic        ref_clk_i = 0, rst_i = 1, soft_rst_i = 0, clk_en_i = 1, speed_100_i = 0;
	logic        tx_err_i = 0, cl = 0, l1 = 0, c1 = 0, mgmt_wr_i, mgmt_hit_o, look;
	logic        override_en_o, force_unlock_o, nrzi_sel_o, scram_en_o, descram_en_o;
	logic [3:0]  tx_nibble_i = 0;
	logic [4:0]  strap = 0, mgmt_addr_i, tx_code_o, phy_addr_o, cq[$];
	logic [15:0] ctl = EXT_CTRL_RESET, mgmt_wdata_i, mgmt_rdata_o, rq[$];
	int          mismatches = 0, samples_checked = 0, cyc = 0;
	always #12.5 ref_clk_i = ~ref_clk_i;
	sta_model i_sta_model (.clk_i(ref_clk_i), .addr_o(mgmt_addr_i), .wr_o(mgmt_wr_i),
		.wdata_o(mgmt_wdata_i), .look_o(look));
	phy_extended_control i_phy_extended_control (.ref_clk_i, .rst_i, .soft_rst_i, .clk_en_i,
		.mgmt_addr_i, .mgmt_wr_i, .mgmt_wdata_i, .mgmt_rdata_o, .mgmt_hit_o,
		.addr4_rxled_pin_i(strap[4]), .addr3_txled_pin_i(strap[3]),
		.addr2_linkled_pin_i(strap[2]), .addr1_colled_pin_i(strap[1]),
		.addr0_actled_pin_i(strap[0]), .speed_100_i, .tx_err_i, .tx_nibble_i, .tx_code_o,
		.phy_addr_o, .override_en_o, .force_unlock_o, .nrzi_sel_o, .scram_en_o, .descram_en_o);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checked %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ====
	// watcher: each result shows one cycle after its request
	always @(posedge ref_clk_i) begin
		l1 <= look;
		c1 <= cl;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	always @(negedge ref_clk_i) begin
		if (l1) check(mgmt_rdata_o, rq.pop_front());
		if (c1) check({11'h0, tx_code_o}, {11'h0, cq.pop_front()});
	end
	// ====
	// drivers, each noting what it expects
	task automatic rd(input logic [4:0] a);
		rq.push_back(a == EXT_CTRL_ADDR ? ctl | {5'h0, strap, 6'h0} : 16'h0000);
		i_sta_model.rd_reg(a);
	endtask
	// reserved bits written as zero; address bits keep the caller's data to prove read-only
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		i_sta_model.wr_reg(a, d & 16'h87ED);
		ctl = a == EXT_CTRL_ADDR ? d & EXT_CTRL_WR_MASK : ctl & 16'h7FFF;
	endtask
	task automatic tx(input logic [3:0] n, input logic e);
		cq.push_back(ctl[2] && e ? (n[3] ? ALT[n[2:0]] : {1'b0, n}) : STD[n]);
		@(posedge ref_clk_i);
		tx_nibble_i <= n;
		tx_err_i <= e;
		cl <= 1;
		@(posedge ref_clk_i);
		cl <= 0;
	endtask
	initial begin
		void'($urandom(31));
		strap = 5'($urandom());
		repeat (16) @(posedge ref_clk_i);
		rst_i <= 0;
		repeat (2) @(posedge ref_clk_i);
		rd(EXT_CTRL_ADDR);
		rd(5'h11);
		$display("reset values done");
		wr(EXT_CTRL_ADDR, 16'hFFFF);
		rd(EXT_CTRL_ADDR);
		wr(5'h05, 16'h0000);
		rd(EXT_CTRL_ADDR);
		$display("override done");
		repeat (8) begin
			wr(EXT_CTRL_ADDR, 16'($urandom()));
			rd(EXT_CTRL_ADDR);
			check(16'({nrzi_sel_o, scram_en_o}), 16'({ctl[3], ~ctl[0] & speed_100_i}));
			check(16'({force_unlock_o, override_en_o, phy_addr_o}), 16'({ctl[5] & speed_100_i, ctl[15], strap}));
			check(16'({descram_en_o, mgmt_hit_o}), 16'({~ctl[0] & speed_100_i, 1'b1}));
			speed_100_i <= 1'($urandom());
		end
		$display("random controls done");
		wr(EXT_CTRL_ADDR, 16'h0025);
		@(posedge ref_clk_i);
		soft_rst_i <= 1;
		@(posedge ref_clk_i);
		soft_rst_i <= 0;
		ctl = EXT_CTRL_RESET;
		rd(EXT_CTRL_ADDR);
		$display("soft reset done");
		// a write while the clock enable is low must not land
		clk_en_i <= 0;
		i_sta_model.wr_reg(EXT_CTRL_ADDR, 16'h0001);
		clk_en_i <= 1;
		rd(EXT_CTRL_ADDR);
		// second hardware reset relatches new strap values
		strap = 5'($urandom());
		rst_i <= 1;
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 0;
		repeat (2) @(posedge ref_clk_i);
		ctl = EXT_CTRL_RESET;
		rd(EXT_CTRL_ADDR);
		$display("enable and hard reset done");
		for (int m = 0; m < 2; m++) begin
			wr(EXT_CTRL_ADDR, m ? 16'h000C : 16'h0008);
			for (int n = 0; n < 16; n++) tx(4'(n), 1);
			tx(4'($urandom()), 0);
		end
		repeat (4) @(posedge ref_clk_i);
		$display("code translation done");
		wrap_up();
	end
endmodule
`default_nettype wire
